// *** crcu_map.svh ***
// Constant map of the checksum calculation unit.
`ifndef CRCU_MAP_SVH
`define CRCU_MAP_SVH

// ----------------------------------------
// Generator polynomials
// ----------------------------------------
`define CRCU_POLY_CRC16 16'h8005
`define CRCU_POLY_CCITT 16'h1021
`define CRCU_POLY_CRC32 32'h04C11DB7

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define CRCU_DATA_W 32
`define CRCU_RESET_REM 32'h00000000
`define CRCU_BYTES_BYTE 3'h1
`define CRCU_BYTES_HALF 3'h2
`define CRCU_BYTES_WORD 3'h4

`endif

// *** crcu_pkg.sv ***
// Types shared by the checksum calculation unit.
package crcu_pkg;

	// ----------------------------------------
	// Polynomial selection, input size and engine state
	// ----------------------------------------
	typedef enum logic [1:0] {
		CRCU_MODE_CRC16 = 2'b00,
		CRCU_MODE_CCITT = 2'b01,
		CRCU_MODE_CRC32 = 2'b10
	} crcu_mode_e;

	typedef enum logic [1:0] {
		CRCU_SIZE_BYTE = 2'b00,
		CRCU_SIZE_HALF = 2'b01,
		CRCU_SIZE_WORD = 2'b10
	} crcu_size_e;

	typedef enum logic [0:0] {
		CRCU_ST_IDLE = 1'b0,
		CRCU_ST_RUN = 1'b1
	} crcu_state_e;

endpackage

// *** crcu_byte_step.sv ***
// One byte of remainder update, most significant data bit first.
`timescale 1ns/100ps
`include "crcu_map.svh"

module crcu_byte_step
	import crcu_pkg::*;
(
	input wire logic [31:0] rem_in,
	input wire logic [7:0] byte_in,
	input wire logic [1:0] mode,
	output logic [31:0] rem_out
);

	logic [31:0] acc;
	logic [15:0] poly16;
	logic fb;

	always_comb
	begin
		acc = rem_in;
		fb = 1'b0;
		case (mode)
			CRCU_MODE_CCITT: poly16 = `CRCU_POLY_CCITT;
			default: poly16 = `CRCU_POLY_CRC16;
		endcase
		for (int i = 0; i < 8; i++)
		begin
			if (mode == CRCU_MODE_CRC32)
			begin
				fb = acc[31] ^ byte_in[7 - i];
				acc = {acc[30:0], 1'b0} ^ (fb ? `CRCU_POLY_CRC32 : 32'h0);
			end
			else
			begin
				fb = acc[15] ^ byte_in[7 - i];
				acc = {16'h0, acc[14:0], 1'b0} ^ (fb ? {16'h0, poly16} : 32'h0);
			end
		end
		rem_out = acc;
	end

endmodule

// *** crcu_core.sv ***
// Checksum calculation unit: input shaping, byte engine and result shaping.
//
// Functional notes
// - A 16-bit mode uses the generator 0x8005.
// - A second 16-bit mode uses the CCITT generator 0x1021.
// - A 32-bit mode uses the Ethernet generator 0x04C11DB7.
// - Complement, byte reversal and bit reversal are chosen apart for data and result.
// - Input may be a byte, half-word or word and only that width is folded in.
// - Software programs the seed from which the remainder starts.
// - A byte costs one clock cycle and a word four.
// - The result is 16 or 32 bits wide to match the polynomial and covers the whole stream.
`timescale 1ns/100ps
`include "crcu_map.svh"

module crcu_core
	import crcu_pkg::*;
#(
	parameter int DATA_W = `CRCU_DATA_W
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [1:0] mode,
	input wire logic data_cmpl,
	input wire logic data_byte_rev,
	input wire logic data_bit_rev,
	input wire logic sum_cmpl,
	input wire logic sum_byte_rev,
	input wire logic sum_bit_rev,
	input wire logic seed_wr,
	input wire logic [31:0] seed_val,
	input wire logic data_wr,
	input wire logic [1:0] data_size,
	input wire logic [31:0] data_in,
	output logic data_ready,
	output logic busy,
	output logic [31:0] crc_out
);

	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	generate
		if (DATA_W != 32)
		begin : g_bad_width
			$error("crcu_core serves a 32-bit data port only");
		end
	endgenerate

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function automatic logic [7:0] rev8(input logic [7:0] b);
		logic [7:0] r;
		r = 8'h0;
		for (int i = 0; i < 8; i++)
		begin
			r[i] = b[7 - i];
		end
		return r;
	endfunction

	// The first byte to fold ends up in bits 31:24, the rest follow below.
	function automatic logic [31:0] data_shape(input logic [31:0] d,
		input logic [1:0] sz, input logic cm, input logic byr, input logic bir);
		logic [31:0] v;
		v = 32'h0;
		case (sz)
			CRCU_SIZE_BYTE: v = {d[7:0], 24'h0};
			CRCU_SIZE_HALF: v = byr ? {d[7:0], d[15:8], 16'h0}
				: {d[15:0], 16'h0};
			default: v = byr ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
		endcase
		for (int i = 0; i < 4; i++)
		begin
			if (bir)
			begin
				v[i*8 +: 8] = rev8(v[i*8 +: 8]);
			end
		end
		if (cm)
		begin
			v = ~v;
		end
		return v;
	endfunction

	function automatic logic [2:0] size_bytes(input logic [1:0] sz);
		case (sz)
			CRCU_SIZE_BYTE: return `CRCU_BYTES_BYTE;
			CRCU_SIZE_HALF: return `CRCU_BYTES_HALF;
			default: return `CRCU_BYTES_WORD;
		endcase
	endfunction

	// Whole-width bit reversal, then byte swap, then complement.
	function automatic logic [31:0] sum_shape(input logic [31:0] r,
		input logic w32, input logic cm, input logic byr, input logic bir);
		logic [31:0] v;
		v = w32 ? r : {16'h0, r[15:0]};
		if (bir)
		begin
			for (int i = 0; i < 32; i++)
			begin
				v[i] = w32 ? r[31 - i] : ((i < 16) ? r[15 - i] : 1'b0);
			end
		end
		if (byr)
		begin
			v = w32 ? {v[7:0], v[15:8], v[23:16], v[31:24]}
				: {16'h0, v[7:0], v[15:8]};
		end
		if (cm)
		begin
			v = w32 ? ~v : {16'h0, ~v[15:0]};
		end
		return v;
	endfunction

	// ----------------------------------------
	// Datapath
	// ----------------------------------------
	crcu_state_e state_ff;
	crcu_state_e nxt_state;
	logic [31:0] rem_ff;
	logic [31:0] hold_ff;
	logic [1:0] left_ff;
	logic [31:0] res_ff;
	logic [31:0] shaped;
	logic [2:0] nbytes;
	logic [31:0] step_rem;
	logic [7:0] step_byte;
	logic [31:0] step_out;
	logic take;
	logic w32;

	assign w32 = (mode == CRCU_MODE_CRC32);
	assign shaped = data_shape(data_in, data_size, data_cmpl, data_byte_rev,
		data_bit_rev);
	assign nbytes = size_bytes(data_size);

	// A write is held off while bytes remain or a seed load is pending.
	assign data_ready = (state_ff == CRCU_ST_IDLE)
		&& !seed_wr;
	assign take = data_wr && data_ready && ce;
	assign busy = (state_ff == CRCU_ST_RUN);

	// The first byte folds on the accepting edge, so one byte costs one cycle.
	assign step_rem = rem_ff;
	assign step_byte = take ? shaped[31:24] : hold_ff[31:24];

	crcu_byte_step u_step (
		.rem_in(step_rem),
		.byte_in(step_byte),
		.mode(mode),
		.rem_out(step_out)
	);

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			CRCU_ST_IDLE:
			begin
				if (take && nbytes != `CRCU_BYTES_BYTE)
				begin
					nxt_state = CRCU_ST_RUN;
				end
			end
			CRCU_ST_RUN:
			begin
				if (seed_wr || left_ff == 2'h1)
				begin
					nxt_state = CRCU_ST_IDLE;
				end
			end
			default: nxt_state = CRCU_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_ff <= CRCU_ST_IDLE;
		end
		else if (ce)
		begin
			state_ff <= nxt_state;
		end
	end

	// Remaining bytes are counted down; a seed load drops any in flight.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			hold_ff <= 32'h0;
			left_ff <= 2'h0;
		end
		else if (ce)
		begin
			if (seed_wr)
			begin
				left_ff <= 2'h0;
			end
			else if (take)
			begin
				hold_ff <= {shaped[23:0], 8'h0};
				left_ff <= 2'(nbytes - 3'h1);
			end
			else if (state_ff == CRCU_ST_RUN)
			begin
				hold_ff <= {hold_ff[23:0], 8'h0};
				left_ff <= left_ff - 2'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rem_ff <= `CRCU_RESET_REM;
		end
		else if (ce)
		begin
			if (seed_wr)
			begin
				rem_ff <= w32 ? seed_val : {16'h0, seed_val[15:0]};
			end
			else if (take || state_ff == CRCU_ST_RUN)
			begin
				rem_ff <= step_out;
			end
		end
	end

	// The result is registered, so it trails the remainder by one cycle.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			res_ff <= `CRCU_RESET_REM;
		end
		else if (ce)
		begin
			res_ff <= sum_shape(rem_ff, w32, sum_cmpl, sum_byte_rev,
				sum_bit_rev);
		end
	end

	assign crc_out = res_ff;

endmodule

// *** crcu_core_asserts.sv ***
// Port timing checker of the checksum unit.
`timescale 1ns/100ps
module crcu_core_asserts
	import crcu_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [1:0] mode,
	input wire logic seed_wr,
	input wire logic data_wr,
	input wire logic [1:0] data_size,
	input wire logic data_ready,
	input wire logic busy,
	input wire logic [31:0] crc_out
);
	wire logic wr_take = ce && data_wr && data_ready;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	a_byte_one_cycle: assert property (
		wr_take && data_size == 2'h0 |=> !busy)
		else $error("byte write left busy set");
	a_byte_back_to_back: assert property (
		wr_take && data_size == 2'h0 ##1 !seed_wr |-> data_ready)
		else $error("byte write blocked the next write");
	a_half_two_cycles: assert property (
		wr_take && data_size == 2'h1 |=> busy ##1 !busy)
		else $error("half write not two cycles");
	a_word_four_cycles: assert property (
		wr_take && data_size[1] ##1 (busy && !seed_wr) [*2]
		|=> busy ##1 !busy)
		else $error("word write not four cycles");
	a_ready_gate: assert property (
		data_ready == (!busy && !seed_wr))
		else $error("ready does not follow busy and seed");
	// A seed only lands on an enabled edge.
	a_seed_abort: assert property (
		ce && seed_wr |=> !busy)
		else $error("seed did not end a pending update");
	a_narrow_upper: assert property (
		(mode != 2'h2) [*2] |-> crc_out[31:16] == 16'h0)
		else $error("upper half set in a 16-bit mode");
	a_result_hold: assert property (
		(!busy && !seed_wr && !wr_take) [*2] |=> $stable(crc_out))
		else $error("result moved without input");
	c_word: cover property (wr_take && data_size[1]);
	c_half: cover property (wr_take && data_size == 2'h1);
	c_abort: cover property (seed_wr && busy);
endmodule
bind crcu_core crcu_core_asserts u_crcu_core_asserts (.clk(clk),
	.nrst(nrst), .ce(ce), .mode(mode), .seed_wr(seed_wr),
	.data_wr(data_wr), .data_size(data_size), .data_ready(data_ready),
	.busy(busy), .crc_out(crc_out));

// *** crcu_master.sv ***
// Bus master model that writes data into the checksum unit.
`timescale 1ns/100ps
module crcu_master
(
	input wire logic clk,
	input wire logic data_ready,
	output logic data_wr,
	output logic [1:0] data_size,
	output logic [31:0] data_in
);
	initial
	begin
		data_wr = 1'b0;
		data_size = 2'h0;
		data_in = 32'h0;
	end
	// A released data bus shows the inverse so stale data cannot pass.
	task automatic stop();
		data_wr = 1'b0;
		data_in = ~data_in;
	endtask
	// Called just after an edge; returns just after the accepting edge.
	task automatic put(input logic [1:0] sz, input logic [31:0] d, input int gap);
		if (gap > 0)
		begin
			stop();
			repeat (gap) @(posedge clk);
			#1;
		end
		data_wr = 1'b1;
		data_size = sz;
		data_in = d;
		while (data_ready !== 1'b1)
		begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
	endtask
endmodule

// *** testbench.sv ***
// Self-checking bench of the checksum unit.
`timescale 1ns/100ps
module testbench;
	import crcu_pkg::*;
	logic clk = 1'b0, nrst, ce, seed_wr, data_wr, data_ready, busy;
	logic [1:0] mode, data_size;
	logic [2:0] dfl, sfl;
	logic [31:0] seed_val, data_in, crc_out, rem, rs = 32'hB, r;
	logic [31:0] notes[$];
	int miscompares = 0, n_checks = 0;
	event chk_ev;
	always #12.5 clk = ~clk;
	crcu_core u_crcu_core (.clk(clk), .nrst(nrst), .ce(ce), .mode(mode),
		.data_cmpl(dfl[0]), .data_byte_rev(dfl[2]), .data_bit_rev(dfl[1]),
		.sum_cmpl(sfl[0]), .sum_byte_rev(sfl[2]), .sum_bit_rev(sfl[1]),
		.seed_wr(seed_wr), .seed_val(seed_val), .data_wr(data_wr),
		.data_size(data_size), .data_in(data_in), .data_ready(data_ready),
		.busy(busy), .crc_out(crc_out));
	crcu_master u_crcu_master (.clk(clk), .data_ready(data_ready),
		.data_wr(data_wr), .data_size(data_size), .data_in(data_in));
	function logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic logic [31:0] fold(logic [31:0] c, logic [31:0] d, int nb);
		logic [31:0] p;
		logic [7:0] b;
		p = mode == 2'h2 ? 32'h04C11DB7
			: mode == 2'h1 ? 32'h1021 : 32'h8005;
		for (int i = nb - 1; i >= 0; i--)
		begin
			b = dfl[2] ? d[8 * (nb - 1 - i) +: 8] : d[8 * i +: 8];
			if (dfl[1])
				b = {<<{b}};
			if (dfl[0])
				b = ~b;
			for (int k = 7; k >= 0; k--)
				if (mode == 2'h2)
					c = {c[30:0], 1'b0} ^ ({32{c[31] ^ b[k]}} & p);
				else
					c = {16'h0, c[14:0], 1'b0} ^ ({32{c[15] ^ b[k]}} & p);
		end
		return c;
	endfunction
	function automatic logic [31:0] shape(logic [31:0] w);
		int n;
		n = mode == 2'h2 ? 32 : 16;
		if (sfl[1])
		begin
			w = {<<{w}};
			w = w >> (32 - n);
		end
		if (sfl[2])
		begin
			if (n == 32)
				w = {<<8{w}};
			else
				w = {16'h0, w[7:0], w[15:8]};
		end
		if (sfl[0])
			w = ~w;
		return n == 32 ? w : {16'h0, w[15:0]};
	endfunction
	task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value crc_out expected %h seen %h", exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic expect_crc(input logic [31:0] e);
		int n;
		n = 0;
		while ((busy !== 1'b0 || data_wr !== 1'b0) && n < 50)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 50)
			miscompares++;
		repeat (2) @(posedge clk);
		#1;
		notes.push_back(e);
		-> chk_ev;
	endtask
	// Mode and flags change only with a seed, so a result never moves idle.
	task automatic seed(input logic [31:0] v, input logic [1:0] m, input logic [5:0] f);
		mode = m;
		{dfl, sfl} = f;
		seed_val = v;
		seed_wr = 1'b1;
		@(posedge clk);
		#1;
		seed_wr = 1'b0;
		rem = m == 2'h2 ? v : {16'h0, v[15:0]};
		expect_crc(shape(rem));
	endtask
	always @(chk_ev)
		compare(crc_out, notes.pop_front());
	initial
	begin
		#500000;
		miscompares++;
		tally_and_finish();
	end
	initial
	begin
		{nrst, seed_wr, seed_val, mode, dfl, sfl} = '0;
		ce = 1'b1;
		repeat (20) @(posedge clk);
		#1;
		nrst = 1'b1;
		expect_crc(32'h0);
		for (int t = 0; t < 32; t++)
		begin
			r = rnd();
			seed(rnd(), t[1:0], r[5:0]);
			for (int i = 0; i < 5; i++)
			begin
				r = rnd();
				u_crcu_master.put(r[1:0], rnd(), r[4] ? int'(r[6:5]) : 0);
				rem = fold(rem, data_in, r[1] ? 4 : r[0] ? 2 : 1);
			end
			u_crcu_master.stop();
			expect_crc(shape(rem));
			$display("test %0d done", t);
		end
		// A seed under a low enable must not land, and nothing may move.
		ce = 1'b0;
		seed_val = ~rem;
		seed_wr = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		seed_wr = 1'b0;
		ce = 1'b1;
		expect_crc(shape(rem));
		u_crcu_master.put(2'h0, rnd(), 0);
		rem = fold(rem, data_in, 1);
		u_crcu_master.stop();
		expect_crc(shape(rem));
		$display("freeze test done");
		fork
		begin
			u_crcu_master.put(2'h2, rnd(), 0);
			u_crcu_master.stop();
		end
		join_none
		repeat (2) @(posedge clk);
		#1;
		seed(rnd(), 2'h2, 6'h0);
		$display("abort test done");
		@(posedge clk);
		tally_and_finish();
	end
endmodule
